// [bench/burst_ctrl_model.sv]
// Purpose: Memory controller model driving the burst port pins
// Assumes: Link clock period is eight clk_i cycles, pins move on clk_i
// Notes:   Released data lines invert every cycle
`default_nettype none

module burst_ctrl_model (
  input  wire logic        clk_i,
  output logic             k_o,
  output logic             c_o,
  output logic             strobe_n_o,
  output logic             rw_o,
  output logic [20:0]      addr_o,
  output logic [35:0]      dq_o,
  output logic [3:0]       sel_n_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] ph  = 3'h0;
  logic       drv = 1'b0;

  initial begin
    k_o = 1'b1;
    c_o = 1'b1;
    strobe_n_o = 1'b1;
    rw_o = 1'b0;
    addr_o = '0;
    dq_o = '0;
    sel_n_o = 4'hf;
  end

  // Output clock lags by one cycle to mimic board skew
  always @(posedge clk_i) begin
    ph <= ph + 3'h1;
    k_o <= (ph == 3'h7) || (ph < 3'h3);
    c_o <= k_o;
    if (!drv) dq_o <= ~dq_o;
  end

  task automatic access(input logic rd, input logic [20:0] a, input logic [35:0] w0, w1,
                        input logic [3:0] s0, s1);
    do @(posedge clk_i); while (ph != 3'h5);
    strobe_n_o <= 1'b0;
    rw_o <= rd;
    addr_o <= a;
    // Hold the bus four cycles early so the invert process never races the task
    drv <= !rd;
    // Word 0 must stand at the k rise after the command
    do @(posedge clk_i); while (ph != 3'h1);
    strobe_n_o <= 1'b1;
    addr_o <= 21'($urandom);
    if (!rd) begin
      dq_o <= w0;
      sel_n_o <= s0;
    end
    // Word 1 must stand at the k fall that follows
    do @(posedge clk_i); while (ph != 3'h1);
    if (!rd) begin
      dq_o <= w1;
      sel_n_o <= s1;
    end
    // Returning after the burst keeps strobes at least two rises apart
    do @(posedge clk_i); while (ph != 3'h5);
    drv <= 1'b0;
    sel_n_o <= 4'hf;
  endtask : access

endmodule : burst_ctrl_model

`default_nettype wire

// [bench/test_ddr_burst_sram_port.sv]
// Purpose: Self-checking bench for the burst memory port
// Assumes: Read words stand five clk_i cycles after each output edge
// Notes:   Expected words are queued when a read is issued
`default_nettype none

module test_ddr_burst_sram_port;
  import sram_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic            clk_i = 1'b0;
  logic            srst_i = 1'b1;
  logic            dll_n = 1'b1;
  logic            single = 1'b0;
  logic [1:0]      mode = 2'h3;
  logic            k, c, strobe_n, rw, oe_n, oclk_q = 1'b0;
  logic [20:0]     addr;
  logic [3:0]      sel_n;
  logic [4:0]      due = 5'h0;
  logic [DQ_W-1:0] ctrl_dq, dev_dq, wire_dq;
  logic [DQ_W-1:0] mem [int] = '{default: '0};
  logic [DQ_W-1:0] exp_q [$];
  int              miscompares = 0;
  int              compares = 0;
  int              cycles = 0;

  always #25 clk_i = ~clk_i;
  assign wire_dq = (oe_n === 1'b0) ? dev_dq : ctrl_dq;

  burst_ctrl_model u_burst_ctrl_model (.clk_i(clk_i), .k_o(k), .c_o(c), .strobe_n_o(strobe_n),
    .rw_o(rw), .addr_o(addr), .dq_o(ctrl_dq), .sel_n_o(sel_n));

  ddr_burst_sram_port u_ddr_burst_sram_port (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
    .k_i(k), .k_n_i(~k), .c_i(c), .c_n_i(~c), .load_strobe_n_i(strobe_n), .read_write_i(rw),
    .addr_i(addr), .dq_i(wire_dq), .nibble_write_sel0_n_i(sel_n[0]),
    .nibble_write_sel1_n_i(sel_n[1]), .byte_write_sel0_n_i(sel_n[0]),
    .byte_write_sel1_n_i(sel_n[1]), .byte_write_sel2_n_i(sel_n[2]),
    .byte_write_sel3_n_i(sel_n[3]), .loop_disable_n_i(dll_n), .single_clock_i(single),
    .width_mode_i(mode), .dq_o(dev_dq), .dq_oe_n_o(oe_n));

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic int key(input logic [20:0] a, input logic b);
    case (mode)
      2'h0, 2'h1: key = int'({a, b});
      2'h2:       key = int'({a[20:1], a[0] ^ b});
      default:    key = int'({a[19:1], a[0] ^ b});
    endcase
  endfunction : key

  function automatic logic [35:0] lanes(input logic [3:0] s);
    lanes = '0;
    for (int i = 0; i < 4; i++) begin
      if (mode == 2'h0 && i < 2 && !s[i]) lanes[i*NIB_W+:NIB_W] = '1;
      if (mode != 2'h0 && !s[i]) lanes[i*BYTE_W+:BYTE_W] = '1;
    end
    lanes &= (mode == 2'h0) ? 36'hff : (mode == 2'h1) ? 36'h1ff :
             (mode == 2'h2) ? 36'h3ffff : 36'hfffffffff;
  endfunction : lanes

  task automatic chk(input string what, input logic [35:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [20:0] a, input logic [35:0] w0, w1, input logic [3:0] s0, s1);
    mem[key(a, 1'b0)] = (mem[key(a, 1'b0)] & ~lanes(s0)) | (w0 & lanes(s0));
    mem[key(a, 1'b1)] = (mem[key(a, 1'b1)] & ~lanes(s1)) | (w1 & lanes(s1));
    u_burst_ctrl_model.access(1'b0, a, w0, w1, s0, s1);
  endtask : wr

  task automatic rd(input logic [20:0] a);
    exp_q.push_back(mem[key(a, 1'b0)] & lanes(4'h0));
    exp_q.push_back(mem[key(a, 1'b1)] & lanes(4'h0));
    u_burst_ctrl_model.access(1'b1, a, '0, '0, 4'hf, 4'hf);
  endtask : rd

  // Straps change only under reset, after the last burst has drained
  task automatic cfg(input logic [1:0] m, input logic d, input logic s);
    if (!srst_i) begin
      repeat (30) @(posedge clk_i);
    end
    mode <= m;
    dll_n <= d;
    single <= s;
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("enable idle", {35'h0, oe_n}, 36'h1);
  endtask : cfg

  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    oclk_q <= single ? k : c;
    due <= {due[3:0], (single ? k : c) ^ oclk_q};
    if (due[4] && oe_n !== 1'b1) begin
      if (exp_q.size() == 0) chk("stray enable", {35'h0, oe_n}, 36'h1);
      else chk("read word", dev_dq, exp_q.pop_front());
    end
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    logic [20:0] a;
    void'($urandom(32'h4f6e));
    for (int m = 3; m >= 0; m--) begin
      cfg(2'(m), 1'b1, 1'b0);
      a = 21'($urandom) & ~21'h1;
      wr(a, 36'({$urandom, $urandom}), 36'({$urandom, $urandom}), 4'h0, 4'h0);
      rd(a);
      if (m >= 2) rd(a | 21'h1);
      for (int i = 0; i < 4; i++) begin
        wr(a, 36'({$urandom, $urandom}), 36'({$urandom, $urandom}), 4'h1 << i, ~(4'h1 << i));
        rd(a);
      end
      $display("width mode %0d done", m);
    end
    for (int j = 0; j < 2; j++) begin
      cfg(2'h3, 1'(j), 1'(j));
      a = 21'($urandom) | 21'h1;
      wr(a, 36'({$urandom, $urandom}), 36'({$urandom, $urandom}), 4'h0, 4'h0);
      rd(a);
      rd(a & ~21'h1);
      $display("latency variant %0d done", j);
    end
    cfg(2'h3, 1'b1, 1'b0);
    chk("pending words", 36'(exp_q.size()), 36'h0);
    results();
  end

endmodule : test_ddr_burst_sram_port

`default_nettype wire

// [src/ddr_burst_sram_port.sv]
// Purpose: Two-word burst double-data-rate static memory port, device side
// Assumes: Link clocks are slow against clk_i and are sampled like data
// Notes:   Read words queue in a FIFO until their output-clock edge
`default_nettype none

module sync_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wptr;
  logic [PW:0]      rptr;

  assign in_ready_o  = (wptr - rptr) != (PW+1)'(DEPTH);
  assign out_valid_o = wptr != rptr;
  assign out_data_o  = store[rptr[PW-1:0]];

  always_ff @(posedge clk_i) begin
    if (ce_i && in_valid_i && in_ready_o) begin
      store[wptr[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wptr <= '0;
      rptr <= '0;
    end else if (ce_i) begin
      if (in_valid_i && in_ready_o) begin
        wptr <= wptr + 1'b1;
      end
      if (out_valid_o && out_ready_i) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

endmodule : sync_fifo

module ddr_burst_sram_port
  import sram_port_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  input  wire logic              k_i,
  input  wire logic              k_n_i,
  input  wire logic              c_i,
  input  wire logic              c_n_i,
  input  wire logic              load_strobe_n_i,
  input  wire logic              read_write_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DQ_W-1:0]   dq_i,
  input  wire logic              nibble_write_sel0_n_i,
  input  wire logic              nibble_write_sel1_n_i,
  input  wire logic              byte_write_sel0_n_i,
  input  wire logic              byte_write_sel1_n_i,
  input  wire logic              byte_write_sel2_n_i,
  input  wire logic              byte_write_sel3_n_i,
  input  wire logic              loop_disable_n_i,
  input  wire logic              single_clock_i,
  input  wire logic [1:0]        width_mode_i,
  output logic      [DQ_W-1:0]   dq_o,
  output logic                   dq_oe_n_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DQ_W-1:0] lane_mask(
    input width_mode_t m,
    input logic [1:0]  nws_n,
    input logic [3:0]  bws_n
  );
    logic [DQ_W-1:0] r;
    r = '0;
    case (m)
      MODE_X8:  r[2*NIB_W-1:0] = {{NIB_W{~nws_n[1]}}, {NIB_W{~nws_n[0]}}};
      MODE_X9:  r[BYTE_W-1:0] = {BYTE_W{~bws_n[0]}};
      MODE_X18: r[2*BYTE_W-1:0] = {{BYTE_W{~bws_n[1]}}, {BYTE_W{~bws_n[0]}}};
      default:  r = {{BYTE_W{~bws_n[3]}}, {BYTE_W{~bws_n[2]}},
                     {BYTE_W{~bws_n[1]}}, {BYTE_W{~bws_n[0]}}};
    endcase
    return r;
  endfunction : lane_mask

  function automatic logic [WIDX_W-1:0] word_index(
    input width_mode_t       m,
    input logic [ADDR_W-1:0] a,
    input logic              beat
  );
    logic [WIDX_W-1:0] r;
    r = '0;
    case (m)
      MODE_X8,
      MODE_X9:  r = {a, beat};
      MODE_X18: r = {1'b0, a[ADDR_W-1:1], a[0] ^ beat};
      default:  r = {2'b00, a[ADDR_W-2:1], a[0] ^ beat};
    endcase
    return r;
  endfunction : word_index

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  pins_t raw;
  pins_t meta;
  pins_t pins;
  pins_t prev;

  assign raw = '{k: k_i, k_n: k_n_i, c: c_i, c_n: c_n_i,
                 load_n: load_strobe_n_i, rd: read_write_i, addr: addr_i,
                 dq: dq_i,
                 nws_n: {nibble_write_sel1_n_i, nibble_write_sel0_n_i},
                 bws_n: {byte_write_sel3_n_i, byte_write_sel2_n_i,
                         byte_write_sel1_n_i, byte_write_sel0_n_i},
                 loop_dis_n: loop_disable_n_i, single_clk: single_clock_i,
                 mode: width_mode_t'(width_mode_i)};

  // All pins share one delay so data stays aligned with its clock edge
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      meta <= raw;
      pins <= meta;
      prev <= pins;
    end
  end

  logic k_rise;
  logic kn_rise;
  logic out_edge;
  logic access;
  logic rd_acc;
  logic wr_acc;

  assign k_rise   = pins.k & ~prev.k;
  assign kn_rise  = pins.k_n & ~prev.k_n;
  assign out_edge = pins.single_clk ? (k_rise | kn_rise)
                  : ((pins.c & ~prev.c) | (pins.c_n & ~prev.c_n));
  assign access   = k_rise & ~pins.load_n;
  assign rd_acc   = access & pins.rd;
  assign wr_acc   = access & ~pins.rd;

  // ----------------------------------------------------------------
  // Memory array and write burst
  // ----------------------------------------------------------------
  logic [DQ_W-1:0]   mem [2**WIDX_W];
  wr_state_t         wr_state;
  logic [ADDR_W-1:0] wr_addr;
  logic              wr_en;
  logic              wr_beat;
  logic [DQ_W-1:0]   wr_mask;
  logic [WIDX_W-1:0] wr_idx;

  assign wr_en   = (wr_state == WR_BEAT0 && k_rise)
                 || (wr_state == WR_BEAT1 && kn_rise);
  assign wr_beat = wr_state == WR_BEAT1;
  assign wr_mask = lane_mask(pins.mode, pins.nws_n, pins.bws_n);
  assign wr_idx  = word_index(pins.mode, wr_addr, wr_beat);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_state <= WR_IDLE;
      wr_addr  <= '0;
    end else if (ce_i) begin
      case (wr_state)
        WR_IDLE: begin
          if (wr_acc) begin
            wr_addr  <= pins.addr;
            wr_state <= WR_BEAT0;
          end
        end
        WR_BEAT0: begin
          if (k_rise) begin
            wr_state <= WR_BEAT1;
          end
        end
        default: begin
          if (kn_rise) begin
            wr_state <= WR_IDLE;
          end
        end
      endcase
    end
  end

  // Unselected lanes keep their old contents
  always_ff @(posedge clk_i) begin
    if (ce_i && wr_en) begin
      mem[wr_idx] <= (mem[wr_idx] & ~wr_mask) | (pins.dq & wr_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read burst into the output FIFO
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] rd_addr;
  logic [1:0]        rd_left;
  logic              rd_beat;
  logic              push_valid;
  logic              push_ready;
  logic [DQ_W-1:0]   push_data;
  logic              pop_valid;
  logic              pop_ready;
  logic [DQ_W-1:0]   pop_data;

  assign push_valid = rd_left != 2'h0;
  assign push_data  = mem[word_index(pins.mode, rd_addr, rd_beat)]
                    & lane_mask(pins.mode, 2'h0, 4'h0);

  // A full FIFO stalls the push; output slots then pop older queued words
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_addr <= '0;
      rd_left <= 2'h0;
      rd_beat <= 1'b0;
    end else if (ce_i) begin
      if (rd_acc) begin
        rd_addr <= pins.addr;
        rd_left <= BURST_FIRST;
        rd_beat <= 1'b0;
      end else if (push_valid && push_ready) begin
        rd_left <= rd_left - 2'h1;
        rd_beat <= 1'b1;
      end
    end
  end

  sync_fifo #(
    .WIDTH (DQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  // ----------------------------------------------------------------
  // Output launch schedule
  // ----------------------------------------------------------------
  logic [3:0] sched;
  logic [3:0] next_sched;

  always_comb begin
    next_sched = out_edge ? {1'b0, sched[3:1]} : sched;
    if (rd_acc) begin
      next_sched = next_sched
                 | (pins.loop_dis_n ? SCHED_DLL_ON : SCHED_DLL_OFF);
    end
  end

  assign pop_ready = out_edge & sched[0];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sched <= 4'h0;
    end else if (ce_i) begin
      sched <= next_sched;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dq_o      <= '0;
      dq_oe_n_o <= 1'b1;
    end else if (ce_i && out_edge) begin
      if (sched[0] && pop_valid) begin
        dq_o      <= pop_data;
        dq_oe_n_o <= 1'b0;
      end else begin
        dq_oe_n_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_rd_cmd;
    ce_i && rd_acc;
  endsequence

  sequence s_wr_cmd;
    ce_i && wr_acc && wr_state == WR_IDLE;
  endsequence

  property p_rd_burst;
    s_rd_cmd |=> rd_left == 2'h2 && !rd_beat;
  endproperty
  a_rd_burst: assert property (p_rd_burst) else $error("read burst not two");

  property p_wr_start;
    s_wr_cmd |=> wr_state == WR_BEAT0 && wr_addr == $past(pins.addr);
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write not started");

  property p_start_on_k;
    wr_state == WR_IDLE && !k_rise |=> wr_state == WR_IDLE;
  endproperty
  a_start_on_k: assert property (p_start_on_k) else $error("start off edge");

  property p_wr_edges;
    wr_en |-> (k_rise && !wr_beat) || (kn_rise && wr_beat);
  endproperty
  a_wr_edges: assert property (p_wr_edges) else $error("write on wrong edge");

  property p_nib_mask;
    pins.mode == MODE_X8 |-> wr_mask[DQ_W-1:8] == '0
      && wr_mask[7:4] == {4{~pins.nws_n[1]}};
  endproperty
  a_nib_mask: assert property (p_nib_mask) else $error("nibble mask wrong");

  property p_byte_mask;
    pins.mode == MODE_X36 |-> wr_mask[35:27] == {9{~pins.bws_n[3]}}
      && wr_mask[17:9] == {9{~pins.bws_n[1]}};
  endproperty
  a_byte_mask: assert property (p_byte_mask) else $error("byte mask wrong");

  property p_addr_hold;
    ce_i && !rd_acc |=> rd_addr == $past(rd_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address taken");

  property p_float;
    ce_i && out_edge && !sched[0] |=> dq_oe_n_o;
  endproperty
  a_float: assert property (p_float) else $error("bus driven idle");

  property p_latency;
    s_rd_cmd ##0 pins.loop_dis_n |=> sched[3:2] == 2'h3;
  endproperty
  a_latency: assert property (p_latency) else $error("latency slot wrong");

endmodule : ddr_burst_sram_port

`default_nettype wire

// [src/sram_port_pkg.sv]
// Purpose: Shared constants and types for the two-word burst memory port
// Assumes: One 20 MHz system clock samples every pin
// Notes:   Data width is that of the widest variant, address widths those of the narrowest
`default_nettype none

package sram_port_pkg;

  localparam int DQ_W       = 36;
  localparam int ADDR_W     = 21;
  localparam int WIDX_W     = 22;
  localparam int BURST_LEN  = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int NIB_W      = 4;
  localparam int BYTE_W     = 9;

  // Output-edge slots of a read burst, bit 0 is the next edge
  localparam logic [3:0] SCHED_DLL_ON  = 4'hc;
  localparam logic [3:0] SCHED_DLL_OFF = 4'h6;
  localparam logic [1:0] BURST_FIRST   = 2'h2;

  typedef enum logic [1:0] {
    MODE_X8,
    MODE_X9,
    MODE_X18,
    MODE_X36
  } width_mode_t;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_BEAT0,
    WR_BEAT1
  } wr_state_t;

  typedef struct packed {
    logic              k;
    logic              k_n;
    logic              c;
    logic              c_n;
    logic              load_n;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq;
    logic [1:0]        nws_n;
    logic [3:0]        bws_n;
    logic              loop_dis_n;
    logic              single_clk;
    width_mode_t       mode;
  } pins_t;

endpackage : sram_port_pkg

`default_nettype wire
